// ==== pcr_consts.vh ====
// Constants for the protocol configuration register bank
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH
`define PCR_ADDR_NETMGMT_VECTOR_BYTES 8'h3E
`define PCR_ADDR_SYNC_FRAME_ID 8'h94
`define PCR_ADDR_SYNCH 8'h96
`define PCR_ADDR_GTICK 8'hAE
`define PCR_ADDR_TSS 8'hBA
`define PCR_ADDR_CSM 8'hC0
`define PCR_ADDR_MOC 8'hDA
`define PCR_ADDR_MRC 8'hDC
`define PCR_ADDR_STAT 8'hE4
`define PCR_SYNC_FRAME_ID_RESET 16'h0000
`define PCR_SUP_BIT 15
`define PCR_NETMGMT_VECTOR_BYTES_MASK 16'h000F
`define PCR_SYNC_FRAME_ID_MASK 16'h87FF
`define PCR_CRC_MASK 16'h07FF
`define PCR_GTICK_MASK 16'h001F
`endif

// ==== pcr_config_bank.v ====
// Protocol configuration register bank with its consumers
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.vh"
module pcr_config_bank #(
  parameter AW = 8
) (
  input wire clock_in,
  input wire nrst_in,
  input wire [AW-1:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  input wire config_state_in,
  input wire [15:0] int_offset_in,
  input wire [15:0] int_rate_in,
  input wire [15:0] ext_offset_in,
  input wire [15:0] ext_rate_in,
  input wire ext_sel_in,
  output reg [15:0] offset_corr_out,
  output reg [15:0] rate_corr_out,
  input wire cs_attempt_in,
  input wire cs_response_in,
  output reg cs_allowed_out,
  output reg cs_listen_out,
  output reg [7:0] start_seq_tx_length_out,
  output reg [7:0] start_seq_rx_max_length_out,
  output reg [3:0] netmgmt_vector_bytes_out,
  output reg [10:0] sync_frame_id_out,
  output reg sync_enable_out,
  output reg startup_node_flag_out,
  input wire [10:0] buf_frame_id_in,
  input wire [10:0] buf_crc_in,
  input wire buf_sync_sel_in,
  output reg [10:0] hdr_crc_out,
  input wire microtick_in,
  output reg guardian_tick_out
);
  reg [15:0] netmgmt_vector_bytes_q, sync_frame_id_q, synch_q, gtick_q, tss_q, csm_q, moc_q, mrc_q;
  reg [15:0] cs_count_q;
  reg cs_lock_q;
  reg cfg_prev_q;
  reg [4:0] tick_cnt_q;
  wire wr_ok;
  wire [15:0] cs_limit;
  wire [4:0] tick_period;

  // Signed magnitude clamp, two's complement correction value
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lim;
    reg [15:0] mag;
    begin
      mag = v[15] ? (~v + 16'h0001) : v;
      if (mag > lim)
        clamp = v[15] ? (~lim + 16'h0001) : lim;
      else
        clamp = v;
    end
  endfunction

  assign wr_ok = wr_in & config_state_in;
  assign cs_limit = csm_q & 16'h7FFF;
  assign tick_period = gtick_q[4:0];

  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      netmgmt_vector_bytes_q <= 16'h0000;
      sync_frame_id_q <= `PCR_SYNC_FRAME_ID_RESET;
      synch_q <= 16'h0000;
      gtick_q <= 16'h0000;
      tss_q <= 16'h0000;
      csm_q <= 16'h0000;
      moc_q <= 16'h0000;
      mrc_q <= 16'h0000;
    end
    else if (wr_ok)
    begin
      case (addr_in)
        `PCR_ADDR_NETMGMT_VECTOR_BYTES: netmgmt_vector_bytes_q <= wdata_in & `PCR_NETMGMT_VECTOR_BYTES_MASK;
        `PCR_ADDR_SYNC_FRAME_ID: sync_frame_id_q <= wdata_in & `PCR_SYNC_FRAME_ID_MASK;
        `PCR_ADDR_SYNCH: synch_q <= wdata_in & `PCR_CRC_MASK;
        `PCR_ADDR_GTICK: gtick_q <= wdata_in & `PCR_GTICK_MASK;
        `PCR_ADDR_TSS: tss_q <= wdata_in;
        `PCR_ADDR_CSM: csm_q <= wdata_in;
        `PCR_ADDR_MOC: moc_q <= wdata_in;
        `PCR_ADDR_MRC: mrc_q <= wdata_in;
        default: netmgmt_vector_bytes_q <= netmgmt_vector_bytes_q;
      endcase
    end
  end

  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= 16'h0000;
    else if (rd_in)
    begin
      case (addr_in)
        `PCR_ADDR_NETMGMT_VECTOR_BYTES: rdata_out <= netmgmt_vector_bytes_q;
        `PCR_ADDR_SYNC_FRAME_ID: rdata_out <= sync_frame_id_q;
        `PCR_ADDR_SYNCH: rdata_out <= synch_q;
        `PCR_ADDR_GTICK: rdata_out <= gtick_q;
        `PCR_ADDR_TSS: rdata_out <= tss_q;
        `PCR_ADDR_CSM: rdata_out <= csm_q;
        `PCR_ADDR_MOC: rdata_out <= moc_q;
        `PCR_ADDR_MRC: rdata_out <= mrc_q;
        `PCR_ADDR_STAT: rdata_out <= cs_count_q;
        default: rdata_out <= 16'h0000;
      endcase
    end
    else
      rdata_out <= 16'h0000;
  end

  // Clock correction outputs
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      offset_corr_out <= 16'h0000;
      rate_corr_out <= 16'h0000;
    end
    else if (ext_sel_in)
    begin
      offset_corr_out <= ext_offset_in;
      rate_corr_out <= ext_rate_in;
    end
    else
    begin
      offset_corr_out <= clamp(int_offset_in, moc_q);
      rate_corr_out <= clamp(int_rate_in, mrc_q);
    end
  end

  // Coldstart attempt budget
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cs_count_q <= 16'h0000;
      cs_lock_q <= 1'b0;
      cfg_prev_q <= 1'b0;
      cs_allowed_out <= 1'b0;
      cs_listen_out <= 1'b0;
    end
    else
    begin
      cfg_prev_q <= config_state_in;
      if (cfg_prev_q & ~config_state_in)
      begin
        cs_count_q <= 16'h0000;
        cs_lock_q <= 1'b0;
      end
      else if (cs_response_in)
        cs_count_q <= 16'h0000;
      else if (cs_attempt_in & ~cs_lock_q & (cs_count_q < cs_limit))
      begin
        cs_count_q <= cs_count_q + 16'h0001;
        if (cs_count_q + 16'h0001 >= cs_limit)
          cs_lock_q <= 1'b1;
      end
      cs_allowed_out <= ~config_state_in & ~cs_lock_q & (cs_limit != 16'h0000) &
        sync_frame_id_q[`PCR_SUP_BIT];
      cs_listen_out <= cs_lock_q;
    end
  end

  // Static configuration fields and header CRC selection
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      start_seq_tx_length_out <= 8'h00;
      start_seq_rx_max_length_out <= 8'h00;
      netmgmt_vector_bytes_out <= 4'h0;
      sync_frame_id_out <= 11'h000;
      sync_enable_out <= 1'b0;
      startup_node_flag_out <= 1'b0;
      hdr_crc_out <= 11'h000;
    end
    else
    begin
      start_seq_tx_length_out <= tss_q[7:0];
      start_seq_rx_max_length_out <= tss_q[15:8];
      netmgmt_vector_bytes_out <= netmgmt_vector_bytes_q[3:0];
      sync_frame_id_out <= sync_frame_id_q[10:0];
      sync_enable_out <= (sync_frame_id_q[10:0] != 11'h000);
      startup_node_flag_out <= sync_frame_id_q[`PCR_SUP_BIT];
      if (buf_sync_sel_in && sync_frame_id_q[10:0] != 11'h000 && buf_frame_id_in == sync_frame_id_q[10:0])
        hdr_crc_out <= synch_q[10:0];
      else
        hdr_crc_out <= buf_crc_in;
    end
  end

  // Guardian tick: one microtick high per period
  always @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tick_cnt_q <= 5'h00;
      guardian_tick_out <= 1'b0;
    end
    else if (microtick_in)
    begin
      if (tick_cnt_q + 5'h01 >= tick_period)
      begin
        tick_cnt_q <= 5'h00;
        guardian_tick_out <= (tick_period != 5'h00);
      end
      else
      begin
        tick_cnt_q <= tick_cnt_q + 5'h01;
        guardian_tick_out <= 1'b0;
      end
    end
    else
      guardian_tick_out <= 1'b0;
  end
endmodule // pcr_config_bank
`default_nettype wire

// ==== pcr_config_chk.sv ====
// Checker for the protocol configuration register bank
`timescale 1ns/1ps
`default_nettype none
module pcr_config_chk (
  input wire logic clock_in, nrst_in, wr_in, config_state_in, ext_sel_in, buf_sync_sel_in,
  input wire logic microtick_in, guardian_tick_out, cs_allowed_out, cs_listen_out,
  input wire logic sync_enable_out, startup_node_flag_out,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in, ext_offset_in, offset_corr_out,
  input wire logic [10:0] sync_frame_id_out, buf_crc_in, hdr_crc_out
);
  logic signed [16:0] lim_q;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  // Shadow of the offset limit
  always_ff @(posedge clock_in or negedge nrst_in)
    if (!nrst_in)
      lim_q <= 17'sh00000;
    else if (wr_in && config_state_in && addr_in == 8'hDA)
      lim_q <= {1'b0, wdata_in};
  sequence held_s;
    $stable(sync_frame_id_out) ##1 $stable(sync_frame_id_out);
  endsequence
  ign_wr_a: assert property (wr_in && !config_state_in && addr_in == 8'h94
    && !$past(wr_in) |=> held_s) else $error("sync id written outside config");
  ext_off_a: assert property (ext_sel_in |=> offset_corr_out == $past(ext_offset_in))
    else $error("external offset altered");
  off_clamp_a: assert property (!ext_sel_in |=> $signed(offset_corr_out) <= $past(lim_q)
    && $signed(offset_corr_out) >= -$past(lim_q)) else $error("offset beyond limit");
  tick_src_a: assert property (guardian_tick_out |-> $past(microtick_in))
    else $error("guardian tick without microtick");
  rst_sync_a: assert property ($rose(nrst_in) |-> sync_frame_id_out == 11'h000
    && !startup_node_flag_out) else $error("sync register not cleared");
  sync_en_a: assert property (sync_enable_out |-> sync_frame_id_out != 11'h000)
    else $error("sync enabled with zero id");
  crc_pass_a: assert property (!buf_sync_sel_in |=> hdr_crc_out == $past(buf_crc_in))
    else $error("header crc replaced wrongly");
  cs_lock_a: assert property (cs_listen_out |-> !cs_allowed_out)
    else $error("coldstart allowed while locked");
endmodule // pcr_config_chk
bind pcr_config_bank pcr_config_chk i_chk (.*);
`default_nettype wire

// ==== test_protocol_config_registers.sv ====
// Testbench for the protocol configuration register bank
`timescale 1ns/1ps
`default_nettype none
module test_protocol_config_registers;
  logic clock_in, nrst_in, wr_in, rd_in, config_state_in, ext_sel_in, cs_attempt_in;
  logic cs_response_in, buf_sync_sel_in, microtick_in, cs_allowed_out, cs_listen_out;
  logic sync_enable_out, startup_node_flag_out, guardian_tick_out;
  logic [7:0] addr_in, start_seq_tx_length_out, start_seq_rx_max_length_out;
  logic [15:0] wdata_in, rdata_out, int_offset_in, int_rate_in, ext_offset_in, ext_rate_in;
  logic [15:0] offset_corr_out, rate_corr_out;
  logic [3:0] netmgmt_vector_bytes_out;
  logic [10:0] sync_frame_id_out, buf_frame_id_in, buf_crc_in, hdr_crc_out;
  int fail_count, checks, n;
  `define CMP(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
  pcr_config_bank i_dut (.*);
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task final_report;
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cyc;
    @(posedge clock_in);
    #1;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clock_in);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge clock_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 `CMP(rdata_out, e)
  endtask
  task t_regs;
    wr(8'h3E, 16'hFFFC);
    wr(8'h94, 16'hF923);
    wr(8'h96, 16'hFAAA);
    wr(8'hAE, 16'hFFE3);
    wr(8'hBA, 16'h2A05);
    wr(8'hC0, 16'h0002);
    wr(8'hDA, 16'h0005);
    wr(8'hDC, 16'h0003);
    rd(8'h3E, 16'h000C);
    rd(8'h94, 16'h8123);
    rd(8'h96, 16'h02AA);
    rd(8'hAE, 16'h0003);
    rd(8'hBA, 16'h2A05);
    rd(8'hC0, 16'h0002);
    rd(8'hDC, 16'h0003);
    rd(8'h50, 16'h0000);
    `CMP({start_seq_rx_max_length_out, start_seq_tx_length_out}, 16'h2A05)
    `CMP(netmgmt_vector_bytes_out, 4'hC)
    `CMP({startup_node_flag_out, sync_enable_out, sync_frame_id_out}, 13'h1923)
  endtask
  task t_lock;
    config_state_in <= 1'b0;
    wr(8'h94, 16'h0000);
    wr(8'hDA, 16'h0100);
    rd(8'h94, 16'h8123);
    rd(8'hDA, 16'h0005);
  endtask
  task t_corr;
    {int_offset_in, int_rate_in} <= {16'd100, 16'hFF00};
    cyc;
    `CMP({offset_corr_out, rate_corr_out}, {16'h0005, 16'hFFFD})
    {int_offset_in, int_rate_in} <= {16'hFF9C, 16'h0002};
    cyc;
    `CMP({offset_corr_out, rate_corr_out}, {16'hFFFB, 16'h0002})
    {ext_sel_in, ext_offset_in, ext_rate_in} <= {1'b1, 16'h1234, 16'h8000};
    cyc;
    `CMP({offset_corr_out, rate_corr_out}, {16'h1234, 16'h8000})
    ext_sel_in <= 1'b0;
  endtask
  task t_cold;
    repeat (2) cyc;
    `CMP(cs_allowed_out, 1'b1)
    repeat (2)
    begin
      cs_attempt_in <= 1'b1;
      cyc;
      cs_attempt_in <= 1'b0;
      cyc;
    end
    cyc;
    `CMP({cs_listen_out, cs_allowed_out}, 2'b10)
    config_state_in <= 1'b1;
    repeat (2) cyc;
    config_state_in <= 1'b0;
    repeat (3) cyc;
    `CMP({cs_listen_out, cs_allowed_out}, 2'b01)
    config_state_in <= 1'b1;
    wr(8'hC0, 16'h0000);
    config_state_in <= 1'b0;
    repeat (3) cyc;
    `CMP(cs_allowed_out, 1'b0)
  endtask
  task t_crc_tick;
    {buf_sync_sel_in, buf_frame_id_in, buf_crc_in} <= {1'b1, 11'h123, 11'h7FF};
    cyc;
    `CMP(hdr_crc_out, 11'h2AA)
    buf_frame_id_in <= 11'h124;
    cyc;
    `CMP(hdr_crc_out, 11'h7FF)
    microtick_in <= 1'b1;
    repeat (3) cyc;
    n = 0;
    repeat (12)
    begin
      cyc;
      n += guardian_tick_out;
    end
    `CMP(n, 4)
  endtask
  task t_reset;
    config_state_in <= 1'b1;
    wr(8'hC0, 16'h0003);
    config_state_in <= 1'b0;
    cyc;
    `CMP(cs_allowed_out, 1'b1)
    cs_attempt_in <= 1'b1;
    cyc;
    cs_attempt_in <= 1'b0;
    cyc;
    rd(8'hE4, 16'h0001);
    cs_response_in <= 1'b1;
    cyc;
    cs_response_in <= 1'b0;
    rd(8'hE4, 16'h0000);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h94, 16'h0000);
    `CMP({startup_node_flag_out, sync_enable_out}, 2'b00)
  endtask
  initial
  begin
    {nrst_in, wr_in, rd_in, ext_sel_in, cs_attempt_in, cs_response_in, buf_sync_sel_in} = '0;
    {microtick_in, addr_in, wdata_in, int_offset_in, int_rate_in, ext_offset_in} = '0;
    {ext_rate_in, buf_frame_id_in, buf_crc_in} = '0;
    config_state_in = 1'b1;
    repeat (8) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h94, 16'h0000);
    t_regs;
    t_lock;
    t_corr;
    t_cold;
    t_crc_tick;
    t_reset;
    final_report;
  end
  initial
  begin
    #100us;
    fail_count++;
    final_report;
  end
endmodule // test_protocol_config_registers
`default_nettype wire
